// >>> bench/tcm_enable_and_wrapper_tb.sv
// Self-checking bench for the memory enable and wrapper block
`default_nettype none
module tcm_enable_and_wrapper_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import tcm_pkg::*;
	logic clk = 0, reset = 1, boot = 0, ctrl_write = 0, slow = 0;
	logic [31:0] ctrl_wdata = 32'h0, ctrl_rdata, i_rdata, d_rdata;
	logic [31:0] bus_rdata, iram_q, dram_q, rd;
	logic isram_enabled, dsram_enabled, i_wait, d_wait, bus_ready;
	core_req_t ifetch = '0, dreq = '0;
	bus_req_t bus_req;
	mem_port_t iram_port, dram_port, seg_port, segw_port;
	int errors = 0, total_checks = 0, bus_count, c;
	always #2.5 clk = ~clk;
	tcm_enable_and_wrapper tcm_enable_and_wrapper_inst (.clk(clk),
		.reset(reset), .sram_boot_enable_pin(boot), .ctrl_write(ctrl_write),
		.ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata),
		.isram_enabled(isram_enabled), .dsram_enabled(dsram_enabled),
		.ifetch(ifetch), .dreq(dreq), .i_wait(i_wait), .d_wait(d_wait),
		.i_rdata(i_rdata), .d_rdata(d_rdata), .bus_req(bus_req),
		.bus_ready(bus_ready), .bus_rdata(bus_rdata), .iram_port(iram_port),
		.iram_q(iram_q), .dram_port(dram_port), .dram_q(dram_q));
	sram_model sram_model_inst (.clk(clk), .port(iram_port), .q(iram_q));
	sram_model sram_model_inst2 (.clk(clk), .port(dram_port), .q(dram_q));
	bus_model bus_model_inst (.clk(clk), .reset(reset), .slow(slow),
		.req(bus_req), .ready(bus_ready), .rdata(bus_rdata),
		.count(bus_count));
	// Same traffic into the two segmented layouts; only their data memory
	// controls are looked at
	tcm_enable_and_wrapper #(.wrap_mode(four_segment_byte_interface))
		tcm_enable_and_wrapper_inst2 (.clk(clk), .reset(reset),
		.sram_boot_enable_pin(boot), .ctrl_write(ctrl_write),
		.ctrl_wdata(ctrl_wdata), .ctrl_rdata(), .isram_enabled(),
		.dsram_enabled(), .ifetch(ifetch), .dreq(dreq), .i_wait(),
		.d_wait(), .i_rdata(), .d_rdata(), .bus_req(),
		.bus_ready(bus_ready), .bus_rdata(bus_rdata), .iram_port(),
		.iram_q(iram_q), .dram_port(seg_port), .dram_q(dram_q));
	tcm_enable_and_wrapper #(.wrap_mode(four_segment_word_interface))
		tcm_enable_and_wrapper_inst3 (.clk(clk), .reset(reset),
		.sram_boot_enable_pin(boot), .ctrl_write(ctrl_write),
		.ctrl_wdata(ctrl_wdata), .ctrl_rdata(), .isram_enabled(),
		.dsram_enabled(), .ifetch(ifetch), .dreq(dreq), .i_wait(),
		.d_wait(), .i_rdata(), .d_rdata(), .bus_req(),
		.bus_ready(bus_ready), .bus_rdata(bus_rdata), .iram_port(),
		.iram_q(iram_q), .dram_port(segw_port), .dram_q(dram_q));
	////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] pat(input logic [31:0] a);
		return {a[15:0], ~a[15:0]};
	endfunction
	task automatic check(input logic [31:0] seen, exp, input string m);
		total_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("Error at %0t: %s seen %h expected %h", $time, m, seen,
				exp);
		end
	endtask
	task automatic stop_test;
		$display("Checks %0d, errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic do_reset(input logic pin);
		@(posedge clk);
		boot <= pin;
		reset <= 1'b1;
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	task automatic ctrl(input logic [31:0] w, input logic [1:0] en);
		@(posedge clk);
		ctrl_write <= 1'b1;
		ctrl_wdata <= w;
		@(posedge clk);
		ctrl_write <= 1'b0;
		@(negedge clk);
		check(ctrl_rdata, w, "control word");
		check({30'h0, isram_enabled, dsram_enabled}, {30'h0, en}, "en");
	endtask
	// Request held until the edge at which wait is sampled low
	task automatic acc(input logic f, w, input logic [1:0] sz,
		input logic [31:0] a, d);
		int n;
		n = 0;
		@(posedge clk);
		if (f)
			ifetch <= '{1'b1, w, sz, a, d};
		else
			dreq <= '{1'b1, w, sz, a, d};
		@(negedge clk);
		while ((f ? i_wait : d_wait) !== 1'b0 && n < 50)
		begin
			@(negedge clk);
			n++;
		end
		check({31'h0, n < 50}, 32'h1, "access not taken");
		@(posedge clk);
		if (f)
			ifetch.valid <= 1'b0;
		else
			dreq.valid <= 1'b0;
		@(negedge clk);
		rd = f ? i_rdata : d_rdata;
	endtask
	task automatic rc(input logic f, input logic [31:0] a, exp);
		acc(f, 1'b0, 2'h2, a, 32'h0);
		check(rd, exp, "read data");
	endtask
	////////////////////////////////////////////////////////////////////
	task automatic t_boot_low;
		// Cold reset keeps the pin low; the high vector is run last, in t_boot_high
		do_reset(1'b0);
		check({30'h0, isram_enabled, dsram_enabled}, 32'h0, "boot");
		check(ctrl_rdata, 32'h0, "boot control");
		slow <= 1'b1;
		c = bus_count;
		rc(1'b0, 32'h0400_0010, pat(32'h0400_0010));
		rc(1'b1, 32'h0000_0020, pat(32'h0000_0020));
		rc(1'b0, 32'h0000_0030, pat(32'h0000_0030));
		acc(1'b0, 1'b1, 2'h2, 32'h0400_0060, 32'h1234_5678);
		check(bus_count, c + 4, "bus transfers");
		slow <= 1'b0;
		$display("boot low done");
	endtask
	task automatic t_enables;
		ctrl(32'h0000_0004, 2'h1);
		c = bus_count;
		acc(1'b0, 1'b1, 2'h2, 32'h0400_0040, 32'h1122_3344);
		acc(1'b0, 1'b1, 2'h0, 32'h0400_0041, 32'h0000_AA00);
		rc(1'b0, 32'h0400_0040, 32'h1122_AA44);
		acc(1'b0, 1'b1, 2'h1, 32'h0400_0042, 32'hBBBB_0000);
		rc(1'b0, 32'h0600_0040, 32'hBBBB_AA44);
		check(bus_count, c, "memory hits");
		rc(1'b0, 32'h0000_0040, pat(32'h0000_0040));
		// Read-modify-write: the data enable read back stays set
		ctrl(32'h0000_1004, 2'h3);
		acc(1'b0, 1'b1, 2'h2, 32'h0000_0050, 32'hCAFE_0001);
		rc(1'b1, 32'h0000_0050, 32'hCAFE_0001);
		rc(1'b0, 32'h0000_0050, 32'hCAFE_0001);
		rc(1'b1, 32'h0400_0040, pat(32'h0400_0040));
		ctrl(32'h0000_1000, 2'h2);
		rc(1'b0, 32'h0000_0050, 32'hCAFE_0001);
		$display("enables done");
	endtask
	task automatic t_retain;
		ctrl(32'h0000_0000, 2'h0);
		rc(1'b0, 32'h0400_0040, pat(32'h0400_0040));
		rc(1'b1, 32'h0000_0050, pat(32'h0000_0050));
		ctrl(32'h0000_1004, 2'h3);
		rc(1'b0, 32'h0400_0040, 32'hBBBB_AA44);
		rc(1'b1, 32'h0000_0050, 32'hCAFE_0001);
		$display("retention done");
	endtask
	// Holds one data access to segment 2 and looks at the macro controls
	// of all three layouts while they stand
	task automatic seg(input logic w, input logic [1:0] sz,
		input logic [1:0] lo, input logic [3:0] ln, input logic [15:0] bs);
		@(posedge clk);
		dreq <= '{1'b1, w, sz, {30'h0100_1011, lo}, 32'h0000_5500};
		@(negedge clk);
		check({28'h0, dram_port.memory_select}, 32'h1, "select");
		check({28'h0, dram_port.memory_write_strobe}, {31'h0, w}, "we");
		check({19'h0, dram_port.memory_word_address}, 32'h1011, "addr");
		check({28'h0, dram_port.byte_lane_write}, {28'h0, ln}, "lanes");
		check({28'h0, seg_port.memory_select}, 32'h4, "seg");
		check({28'h0, seg_port.memory_write_strobe}, {29'h0, w, 2'h0}, "");
		check({19'h0, seg_port.memory_word_address}, 32'h11, "seg a");
		check({16'h0, seg_port.byte_select}, {16'h0, bs}, "bytes");
		check({28'h0, segw_port.memory_select}, 32'h4, "wseg");
		check({16'h0, segw_port.byte_select}, 32'h0, "no bytes");
		@(posedge clk);
		dreq.valid <= 1'b0;
	endtask
	task automatic t_segments;
		seg(1'b1, 2'h0, 2'h1, 4'h2, 16'h0200);
		seg(1'b0, 2'h2, 2'h0, 4'h0, 16'h0F00);
		$display("segments done");
	endtask
	task automatic t_boot_high;
		do_reset(1'b1);
		check({30'h0, isram_enabled, dsram_enabled}, 32'h3, "boot en");
		check(ctrl_rdata, 32'h0000_1004, "boot control");
		c = bus_count;
		rc(1'b0, 32'h0400_0040, 32'hBBBB_AA44);
		rc(1'b1, 32'h0000_0050, 32'hCAFE_0001);
		check(bus_count, c, "no bus use");
		$display("boot high done");
	endtask
	initial
	begin
		t_boot_low;
		t_enables;
		t_retain;
		t_segments;
		t_boot_high;
		stop_test;
	end
	// Whole run is about a hundred cycles; the limit of 10000 cycles leaves a wide margin
	initial
	begin
		#50000;
		errors++;
		$display("Error at %0t: watchdog expired", $time);
		stop_test;
	end
endmodule
`default_nettype wire

// >>> bench/tcm_far_side_model.sv
// Memory macro and system bus models facing the memory block
`default_nettype none
module sram_model
(
	input wire logic clk,
	input wire tcm_pkg::mem_port_t port,
	output logic [31:0] q
);
	import tcm_pkg::*;
	logic [31:0] mem [0:8191];
	logic [31:0] last_r;
	logic sel_r;
	logic wr;
	assign wr = port.memory_select[0] & port.memory_write_strobe[0];
	// Read data one cycle after select; idle output is inverted so that
	// stale data cannot pass for a fresh read
	always_ff @(posedge clk)
	begin
		sel_r <= port.memory_select[0];
		if (port.memory_select[0])
			last_r <= mem[port.memory_word_address];
		for (int i = 0; i < 4; i++)
			if (wr && port.byte_lane_write[i])
				mem[port.memory_word_address][8*i+:8] <= port.wdata[8*i+:8];
	end
	assign q = sel_r ? last_r : ~last_r;
endmodule
////////////////////////////////////////////////////////////////////////
module bus_model
(
	input wire logic clk,
	input wire logic reset,
	input wire logic slow,
	input wire tcm_pkg::bus_req_t req,
	output logic ready,
	output logic [31:0] rdata,
	output var int count
);
	import tcm_pkg::*;
	logic [1:0] wait_r;
	logic [31:0] pat;
	// Slow mode adds two wait cycles to every transfer
	assign ready = req.valid && (!slow || wait_r == 2'h2);
	assign pat = {req.addr[15:0], ~req.addr[15:0]};
	assign rdata = ready ? pat : ~pat;
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			wait_r <= 2'h0;
		else if (ready || !req.valid)
			wait_r <= 2'h0;
		else
			wait_r <= wait_r + 2'h1;
	end
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			count <= 0;
		else if (ready)
			count <= count + 1;
	end
endmodule
`default_nettype wire

// >>> rtl/tcm_enable_and_wrapper.sv
// Memory enable, routing and memory wrapper for the tightly coupled memories
`include "tcm_map.svh"
`default_nettype none
module tcm_enable_and_wrapper
#(
	parameter tcm_pkg::wrap_mode_t wrap_mode =
		tcm_pkg::single_segment_word_interface
)
(
	input wire logic clk,
	input wire logic reset,
	input wire logic sram_boot_enable_pin,
	input wire logic ctrl_write,
	input wire logic [31:0] ctrl_wdata,
	output logic [31:0] ctrl_rdata,
	output logic isram_enabled,
	output logic dsram_enabled,
	input wire tcm_pkg::core_req_t ifetch,
	input wire tcm_pkg::core_req_t dreq,
	output logic i_wait,
	output logic d_wait,
	output logic [31:0] i_rdata,
	output logic [31:0] d_rdata,
	output tcm_pkg::bus_req_t bus_req,
	input wire logic bus_ready,
	input wire logic [31:0] bus_rdata,
	output tcm_pkg::mem_port_t iram_port,
	input wire logic [31:0] iram_q,
	output tcm_pkg::mem_port_t dram_port,
	input wire logic [31:0] dram_q
);
	import tcm_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic in_region(input logic [31:0] a,
		input logic [5:0] r);
		return a[`REGION_HI:`REGION_LO] == r;
	endfunction

	function automatic logic [3:0] lane_mask(input logic [1:0] size,
		input logic [1:0] a);
		logic [3:0] m;
		m = 4'hF;
		case (size)
			`SIZE_BYTE: m = 4'h1 << a;
			`SIZE_HALF: m = a[1] ? 4'hC : 4'h3;
			default: m = 4'hF;
		endcase
		return m;
	endfunction

	// Shapes one access into the select pattern of the chosen macro layout
	function automatic mem_port_t wrap(input logic valid,
		input core_req_t r);
		mem_port_t p;
		logic [12:0] wa;
		logic [3:0] seg;
		logic [3:0] lanes;
		p = '0;
		wa = r.addr[`WORD_HI:`WORD_LO];
		seg = valid ? (4'h1 << wa[`SEG_HI:`SEG_LO]) : 4'h0;
		lanes = (valid && r.write) ? lane_mask(r.size, r.addr[1:0]) : 4'h0;
		p.byte_lane_write = lanes;
		p.wdata = r.wdata;
		case (wrap_mode)
			single_segment_word_interface:
			begin
				p.memory_select = {3'h0, valid};
				p.memory_write_strobe = {3'h0, valid && r.write};
				p.memory_word_address = wa;
			end
			four_segment_word_interface,
			four_segment_byte_interface:
			begin
				p.memory_select = seg;
				p.memory_write_strobe = r.write ? seg : 4'h0;
				p.memory_word_address = {2'h0, wa[`SEG_ADDR_HI:0]};
				if (wrap_mode == four_segment_byte_interface)
				begin
					for (int s = 0; s < 4; s++)
					begin
						for (int b = 0; b < 4; b++)
						begin
							p.byte_select[s * 4 + b] = seg[s] &&
								(!r.write || lanes[b]);
						end
					end
				end
			end
			default:
			begin
				p.memory_select = 4'h0;
			end
		endcase
		return p;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Boot strap capture and control word

	logic boot_meta_r;
	logic boot_sync_r;
	logic boot_pending_r;
	logic [31:0] ctrl_r;

	// No reset here so the strap is already settled when reset is released
	always_ff @(posedge clk)
	begin
		boot_meta_r <= sram_boot_enable_pin;
		boot_sync_r <= boot_meta_r;
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			boot_pending_r <= 1'b1;
		else
			boot_pending_r <= 1'b0;
	end

	// Software writes the whole word, so other bits survive only when it
	// writes back what it read
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			ctrl_r <= `CTRL_RESET;
		else if (boot_pending_r)
		begin
			ctrl_r[`CTRL_ISRAM_BIT] <= boot_sync_r;
			ctrl_r[`CTRL_DSRAM_BIT] <= boot_sync_r;
		end
		else if (ctrl_write)
			ctrl_r <= ctrl_wdata;
	end

	logic ien;
	logic den;
	assign ien = ctrl_r[`CTRL_ISRAM_BIT];
	assign den = ctrl_r[`CTRL_DSRAM_BIT];
	assign ctrl_rdata = ctrl_r;
	assign isram_enabled = ien;
	assign dsram_enabled = den;

	////////////////////////////////////////////////////////////////////////
	// Routing

	logic i_to_isram;
	logic i_to_bus;
	logic d_to_isram;
	logic d_to_dsram;
	logic d_to_bus;
	logic i_take;
	logic d_take;

	// Upper address bits are ignored inside a region, so a small macro
	// aliases across its whole 64 MB window
	assign i_to_isram = ifetch.valid && ien &&
		in_region(ifetch.addr, `REGION_ISRAM);
	assign i_to_bus = ifetch.valid && !i_to_isram;
	assign d_to_isram = dreq.valid && ien &&
		in_region(dreq.addr, `REGION_ISRAM);
	assign d_to_dsram = dreq.valid && den &&
		in_region(dreq.addr, `REGION_DSRAM);
	assign d_to_bus = dreq.valid && !d_to_isram && !d_to_dsram;

	// The data side wins both the shared instruction memory and the bus;
	// the fetch waits while the data request targets the same one, or, on the bus, also while bus_ready is low
	assign d_wait = d_to_bus && !bus_ready;
	assign i_wait = (i_to_isram && d_to_isram) ||
		(i_to_bus && (d_to_bus || !bus_ready));
	assign i_take = ifetch.valid && !i_wait;
	assign d_take = dreq.valid && !d_wait;

	always_comb
	begin
		bus_req = '0;
		if (d_to_bus)
		begin
			bus_req.valid = 1'b1;
			bus_req.write = dreq.write;
			bus_req.size = dreq.size;
			bus_req.addr = dreq.addr;
			bus_req.wdata = dreq.wdata;
		end
		else if (i_to_bus)
		begin
			bus_req.valid = 1'b1;
			bus_req.fetch = 1'b1;
			bus_req.size = ifetch.size;
			bus_req.addr = ifetch.addr;
		end
	end

	// A disabled memory sees no select at all, so its contents stay put
	// Each memory gets its own wrapper call, but both share one layout; each takes its word address from the request routed to it
	always_comb
	begin
		if (d_to_isram)
			iram_port = wrap(1'b1, dreq);
		else
			iram_port = wrap(i_to_isram, ifetch);
		dram_port = wrap(d_to_dsram, dreq);
	end

	////////////////////////////////////////////////////////////////////////
	// Read return, one cycle after the access is taken

	logic i_from_isram_r;
	logic d_from_isram_r;
	logic d_from_dsram_r;
	logic [31:0] bus_data_r;

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			i_from_isram_r <= 1'b0;
			d_from_isram_r <= 1'b0;
			d_from_dsram_r <= 1'b0;
		end
		else
		begin
			i_from_isram_r <= i_take && i_to_isram;
			d_from_isram_r <= d_take && d_to_isram;
			d_from_dsram_r <= d_take && d_to_dsram;
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			bus_data_r <= 32'h0000_0000;
		else if (bus_req.valid && bus_ready && !bus_req.write)
			bus_data_r <= bus_rdata;
	end

	assign i_rdata = i_from_isram_r ? iram_q : bus_data_r;
	assign d_rdata = d_from_isram_r ? iram_q :
		(d_from_dsram_r ? dram_q : bus_data_r);

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking @(posedge clk);
	endclocking
	default disable iff (reset);

	chk_boot_low_off: assert property (
		boot_pending_r && !boot_sync_r |=> !ien && !den)
		else $error("memories not off after boot with pin low");

	chk_boot_high_on: assert property (
		boot_pending_r && boot_sync_r |=> ien && den)
		else $error("memories not on after boot with pin high");

	chk_ctrl_write: assert property (
		!boot_pending_r && ctrl_write |=> ctrl_rdata == $past(ctrl_wdata))
		else $error("control word did not take the write");

	chk_ifetch_served: assert property (
		i_to_isram && !d_to_isram |->
			iram_port.memory_select != 4'h0 ##1 i_from_isram_r)
		else $error("fetch not served by instruction memory");

	chk_ifetch_bus: assert property (
		ifetch.valid && !ien && !dreq.valid |->
			bus_req.valid && bus_req.fetch)
		else $error("fetch with memory off not sent to bus");

	chk_dsram_served: assert property (
		d_to_dsram |-> dram_port.memory_select != 4'h0 ##1 d_from_dsram_r)
		else $error("data access not served by data memory");

	chk_dsram_off_idle: assert property (
		!den |-> dram_port.memory_select == 4'h0 &&
			dram_port.memory_write_strobe == 4'h0)
		else $error("disabled data memory was selected");

	chk_data_to_iram: assert property (
		dreq.valid && ien && in_region(dreq.addr, `REGION_ISRAM) |->
			!d_wait ##1 d_from_isram_r)
		else $error("data access to instruction range misrouted");

	chk_one_segment: assert property (
		$onehot0(iram_port.memory_select) &&
			$onehot0(dram_port.memory_select))
		else $error("more than one segment selected");

	chk_byte_lane: assert property (
		d_to_dsram && dreq.write && dreq.size == `SIZE_BYTE |->
			$onehot(dram_port.byte_lane_write))
		else $error("byte write drives other than one lane");

	chk_iram_off_idle: assert property (
		!ien |-> iram_port.memory_select == 4'h0 &&
			iram_port.memory_write_strobe == 4'h0)
		else $error("disabled instruction memory was selected");

	chk_seg_select: assert property (
		d_to_dsram && wrap_mode != single_segment_word_interface |->
			dram_port.memory_select == (4'h1 << dreq.addr[14:13]))
		else $error("segment select not from word bits 12 to 11");

	chk_seg_address: assert property (
		d_to_dsram && wrap_mode != single_segment_word_interface |->
			dram_port.memory_word_address == {2'h0, dreq.addr[12:2]})
		else $error("segment address not the low word bits");

	chk_byte_select: assert property (
		d_to_dsram && wrap_mode == four_segment_byte_interface |->
			$countones(dram_port.byte_select) ==
				(dreq.write ? $countones(dram_port.byte_lane_write) : 4))
		else $error("byte selects do not follow the lanes");

endmodule
`default_nettype wire

// >>> rtl/tcm_map.svh
// Constants for the tightly coupled memory enable and wrapper block
`ifndef TCM_MAP_SVH
`define TCM_MAP_SVH
`define CTRL_DSRAM_BIT 2
`define CTRL_ISRAM_BIT 12
`define CTRL_RESET 32'h0000_0000
`define REGION_HI 31
`define REGION_LO 26
`define REGION_ISRAM 6'h00
`define REGION_DSRAM 6'h01
`define WORD_HI 14
`define WORD_LO 2
`define SEG_HI 12
`define SEG_LO 11
`define SEG_ADDR_HI 10
`define SIZE_BYTE 2'h0
`define SIZE_HALF 2'h1
`endif

// >>> rtl/tcm_pkg.sv
// Types shared by the tightly coupled memory enable and wrapper block
`default_nettype none
package tcm_pkg;
	typedef enum logic [2:0]
	{
		single_segment_word_interface = 3'h1,
		four_segment_word_interface = 3'h2,
		four_segment_byte_interface = 3'h4
	} wrap_mode_t;

	typedef struct packed
	{
		logic valid;
		logic write;
		logic [1:0] size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} core_req_t;

	typedef struct packed
	{
		logic valid;
		logic fetch;
		logic write;
		logic [1:0] size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} bus_req_t;

	typedef struct packed
	{
		logic [3:0] memory_select;
		logic [3:0] memory_write_strobe;
		logic [15:0] byte_select;
		logic [3:0] byte_lane_write;
		logic [12:0] memory_word_address;
		logic [31:0] wdata;
	} mem_port_t;
endpackage
`default_nettype wire
